// ### verilog/shk_pkg.sv
// Constants shared by the housekeeping command block.
package shk_pkg;
    localparam logic [15:0] CMD_FW_VERSION   = 16'hD100;
    localparam logic [15:0] CMD_STATUS_READ  = 16'hD206;
    localparam logic [15:0] CMD_STATUS_CLEAR = 16'hD210;
    localparam logic [15:0] CMD_SOFT_RESET   = 16'hD304;
    localparam logic [7:0]  CRC_POLY         = 8'h31;
    localparam logic [7:0]  CRC_INIT         = 8'hFF;
    localparam logic [7:0]  RESERVED_BYTE    = 8'h00;
    localparam logic [2:0]  FW_REPLY_LEN     = 3'h3;
    localparam logic [2:0]  STATUS_REPLY_LEN = 3'h6;
    localparam logic [31:0] STATUS_RESET     = 32'h0000_0000;
    localparam logic [7:0]  FW_VERSION_RESET = 8'h01;
    typedef enum logic [1:0] {ST_IDLE, ST_SEND} shk_state_e;
endpackage

// ### verilog/shk_core.sv
// Housekeeping command decoder and reply serialiser.
`timescale 1ns/1ns
`default_nettype none
module shk_core
    import shk_pkg::*;
#(
    parameter logic [7:0] FW_VERSION = FW_VERSION_RESET
)
(
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    input  wire logic        cmd_valid_i,
    input  wire logic [15:0] cmd_code_i,
    input  wire logic [31:0] status_set_i,
    input  wire logic        tx_ready_i,
    output var  logic        tx_valid_o,
    output var  logic [7:0]  tx_byte_o,
    output var  logic        busy_o,
    output var  logic        soft_reset_o,
    output var  logic [31:0] status_o
);
    // CRC of a two-byte word, MSB first.
    function automatic logic [7:0] crc_word(input logic [15:0] w);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--)
        begin
            if (c[7] ^ w[i])
                c = {c[6:0], 1'b0} ^ CRC_POLY;
            else
                c = {c[6:0], 1'b0};
        end
        return c;
    endfunction

    shk_state_e  state_q, state_d;
    logic [47:0] frame_q, frame_d;
    logic [2:0]  left_q, left_d;
    logic [31:0] status_q, status_d;
    logic        tx_valid_q, tx_valid_d;
    logic        srst_q, srst_d;

    always_comb
    begin
        state_d    = state_q;
        frame_d    = frame_q;
        left_d     = left_q;
        status_d   = status_q;
        tx_valid_d = tx_valid_q;
        srst_d     = 1'b0;
        case (state_q)
            ST_IDLE:
            begin
                tx_valid_d = 1'b0;
                if (cmd_valid_i)
                begin
                    case (cmd_code_i)
                        CMD_FW_VERSION:
                        begin
                            frame_d = {FW_VERSION, RESERVED_BYTE,
                                       crc_word({FW_VERSION, RESERVED_BYTE}), 24'h000000};
                            left_d     = FW_REPLY_LEN;
                            state_d    = ST_SEND;
                            tx_valid_d = 1'b1;
                        end
                        CMD_STATUS_READ:
                        begin
                            // Snapshot keeps both words coherent while flags keep moving.
                            frame_d = {status_q[31:16], crc_word(status_q[31:16]),
                                       status_q[15:0], crc_word(status_q[15:0])};
                            left_d     = STATUS_REPLY_LEN;
                            state_d    = ST_SEND;
                            tx_valid_d = 1'b1;
                        end
                        CMD_STATUS_CLEAR:
                            status_d = STATUS_RESET;
                        CMD_SOFT_RESET:
                            srst_d = 1'b1;
                        default:
                            ;
                    endcase
                end
            end
            ST_SEND:
            begin
                if (tx_ready_i)
                begin
                    // Each taken byte shifts the next one into the top of the frame.
                    frame_d = {frame_q[39:0], 8'h00};
                    left_d  = left_q - 3'h1;
                    if (left_q == 3'h1)
                    begin
                        tx_valid_d = 1'b0;
                        state_d    = ST_IDLE;
                    end
                end
            end
            default:
                state_d = ST_IDLE;
        endcase
        // New events win over a clear in the same cycle.
        status_d = status_d | status_set_i;
        if (srst_q)
        begin
            // Pulse of srst_q restores power-on values everywhere; events and commands in
            // that cycle are dropped, so soft_reset_o never lasts more than one cycle.
            srst_d     = 1'b0;
            state_d    = ST_IDLE;
            frame_d    = '0;
            left_d     = '0;
            status_d   = STATUS_RESET;
            tx_valid_d = 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_q    <= ST_IDLE;
            frame_q    <= '0;
            left_q     <= '0;
            status_q   <= STATUS_RESET;
            tx_valid_q <= 1'b0;
            srst_q     <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            frame_q    <= frame_d;
            left_q     <= left_d;
            status_q   <= status_d;
            tx_valid_q <= tx_valid_d;
            srst_q     <= srst_d;
        end
    end

    // Outputs are plain copies of registers, except busy_o, which decodes state_q.
    always_comb
    begin
        tx_valid_o   = tx_valid_q;
        tx_byte_o    = frame_q[47:40];
        busy_o       = (state_q == ST_SEND);
        soft_reset_o = srst_q;
        status_o     = status_q;
    end

    // Commands that land in the soft reset cycle are dropped, so the sequences exclude it.
    sequence s_fw_cmd;
        cmd_valid_i && state_q == ST_IDLE && !srst_q && cmd_code_i == CMD_FW_VERSION;
    endsequence
    sequence s_st_cmd;
        cmd_valid_i && state_q == ST_IDLE && !srst_q && cmd_code_i == CMD_STATUS_READ;
    endsequence
    sequence s_clr_cmd;
        cmd_valid_i && state_q == ST_IDLE && !srst_q && cmd_code_i == CMD_STATUS_CLEAR;
    endsequence
    sequence s_rst_cmd;
        cmd_valid_i && state_q == ST_IDLE && !srst_q && cmd_code_i == CMD_SOFT_RESET;
    endsequence

    chk_fw_first_byte: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        s_fw_cmd |=> tx_valid_o && tx_byte_o == FW_VERSION)
        else $error("version byte not first");
    chk_fw_reserved: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        s_fw_cmd ##1 tx_ready_i |=> tx_byte_o == RESERVED_BYTE)
        else $error("version reserved byte wrong");
    chk_fw_crc_byte: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        s_fw_cmd ##1 tx_ready_i [*2] |=> tx_byte_o == crc_word({FW_VERSION, RESERVED_BYTE}))
        else $error("version checksum wrong");
    chk_fw_length: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        s_fw_cmd ##1 tx_ready_i [*3] |=> !tx_valid_o)
        else $error("version reply length wrong");

    chk_st_upper_first: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        s_st_cmd |=> tx_byte_o == $past(status_q[31:24]))
        else $error("status upper byte not first");
    chk_st_second: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        s_st_cmd ##1 tx_ready_i |=> tx_byte_o == $past(status_q[23:16], 2))
        else $error("status second byte wrong");
    chk_st_crc_upper: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        s_st_cmd ##1 tx_ready_i [*2] |=> tx_byte_o == crc_word($past(status_q[31:16], 3)))
        else $error("status upper checksum wrong");
    chk_st_lower: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        s_st_cmd ##1 tx_ready_i [*3] |=> tx_byte_o == $past(status_q[15:8], 4))
        else $error("status lower word misplaced");
    chk_st_crc_lower: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        s_st_cmd ##1 tx_ready_i [*5] |=> tx_byte_o == crc_word($past(status_q[15:0], 6)))
        else $error("status lower checksum wrong");
    chk_st_length: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        s_st_cmd ##1 tx_ready_i [*6] |=> !tx_valid_o)
        else $error("status reply length wrong");
    // A stalled byte must stand untouched until the host takes it.
    chk_byte_holds: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
        else $error("stalled reply byte moved");
    chk_clear_flags: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        s_clr_cmd |=> status_o == $past(status_set_i))
        else $error("status clear failed");
    // Flags raised in any cycle but a soft reset pulse survive into the next, a clear in the same cycle included.
    chk_set_sticky: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !srst_q |=> (status_o & $past(status_set_i)) == $past(status_set_i))
        else $error("status event lost");
    chk_busy_refuse: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        busy_o && cmd_valid_i |=> status_o == ($past(status_o) | $past(status_set_i)))
        else $error("command taken while busy");
    chk_soft_reset: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        s_rst_cmd |=> soft_reset_o ##1 (!tx_valid_o && !busy_o && status_o == STATUS_RESET))
        else $error("soft reset incomplete");
    chk_srst_pulse: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        soft_reset_o |=> !soft_reset_o)
        else $error("soft reset pulse too long");
    chk_valid_busy: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        tx_valid_o == busy_o)
        else $error("valid and busy disagree");
endmodule
`default_nettype wire

// ### tb/shk_host.sv
// Host model that takes reply bytes, at once or with stalls.
`timescale 1ns/1ns
`default_nettype none
module shk_host
(
    input  wire logic       clock_i,
    input  wire logic       slow_i,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_byte_i,
    output var  logic       tx_ready_o
);
    logic [7:0] rx_q [0:7];
    int         n_rx   = 0;
    logic       tog    = 1'b0;
    logic       slow_q = 1'b0;
    // Stall mode is taken on the rising edge, clear of the falling edge where the bench moves it.
    always @(posedge clock_i)
        slow_q <= slow_i;
    // Bytes are kept in arrival order so word order and checksum place can be judged.
    always @(posedge clock_i)
        if (tx_valid_i && tx_ready_o)
        begin
            rx_q[n_rx[2:0]] <= tx_byte_i;
            n_rx            <= n_rx + 1;
        end
    always @(negedge clock_i)
    begin
        tog        <= ~tog;
        tx_ready_o <= ~slow_q | tog;
    end
endmodule
`default_nettype wire

// ### tb/shk_core_tb.sv
// Self-checking bench for the housekeeping command block.
`timescale 1ns/1ns
`default_nettype none
module shk_core_tb
    import shk_pkg::*;
;
    logic clock_i, rst_b_i, cmd_valid_i, slow, rdy, tx_valid_o, busy_o, soft_reset_o;
    logic [15:0] cmd_code_i;
    logic [31:0] status_set_i, status_o;
    logic [7:0]  tx_byte_o;
    int          n_fail = 0;
    int          n_checks = 0;
    localparam logic [31:0] PAT = 32'hA5C3_0F81;
    // A code the block does not decode.
    localparam logic [15:0] BAD_CODE = 16'hD200;
    shk_core shk_core_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .cmd_valid_i(cmd_valid_i),
        .cmd_code_i(cmd_code_i), .status_set_i(status_set_i), .tx_ready_i(rdy),
        .tx_valid_o(tx_valid_o), .tx_byte_o(tx_byte_o), .busy_o(busy_o),
        .soft_reset_o(soft_reset_o), .status_o(status_o));
    shk_host shk_host_inst (.clock_i(clock_i), .slow_i(slow), .tx_valid_i(tx_valid_o),
        .tx_byte_i(tx_byte_o), .tx_ready_o(rdy));
    initial
    begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CRC_POLY : 8'h00);
        return c;
    endfunction
    task automatic cmd(input logic [15:0] code);
        @(negedge clock_i);
        cmd_valid_i = 1'b1;
        cmd_code_i  = code;
        @(negedge clock_i);
        cmd_valid_i = 1'b0;
    endtask
    task automatic wait_for(ref logic sig, input logic lvl);
        int k;
        for (k = 0; k < 200 && sig !== lvl; k++)
            @(negedge clock_i);
        if (k == 200)
        begin
            n_fail++;
            summarize();
        end
    endtask
    // A clear sent while a reply is running must be dropped, so the flags survive it.
    task automatic xfer(input logic [15:0] code, input int n, input logic [47:0] e,
                        input logic intrude);
        int base;
        base = shk_host_inst.n_rx;
        cmd(code);
        if (intrude)
            cmd(CMD_STATUS_CLEAR);
        wait_for(busy_o, 1'b0);
        check(shk_host_inst.n_rx - base, n);
        for (int k = 0; k < n; k++)
            check(32'(shk_host_inst.rx_q[(base + k) % 8]), 32'(e[47 - 8 * k -: 8]));
    endtask
    task automatic run_version();
        logic [47:0] e;
        e = {FW_VERSION_RESET, RESERVED_BYTE,
             crc8({FW_VERSION_RESET, RESERVED_BYTE}), 24'h000000};
        xfer(CMD_FW_VERSION, 3, e, 1'b0);
    endtask
    // The fast read keeps the host ready every cycle, the slow one is ready only every other cycle.
    task automatic run_status();
        logic [47:0] e;
        e = {PAT[31:16], crc8(PAT[31:16]), PAT[15:0], crc8(PAT[15:0])};
        @(negedge clock_i);
        status_set_i = PAT;
        @(negedge clock_i);
        status_set_i = '0;
        slow         = 1'b0;
        xfer(CMD_STATUS_READ, 6, e, 1'b0);
        slow = 1'b1;
        xfer(CMD_STATUS_READ, 6, e, 1'b1);
        check(status_o, PAT);
    endtask
    // A flag raised in the very cycle of a clear must survive the clear.
    task automatic run_clear();
        cmd(CMD_STATUS_CLEAR);
        check(status_o, STATUS_RESET);
        @(negedge clock_i);
        status_set_i = ~PAT;
        @(negedge clock_i);
        cmd_valid_i  = 1'b1;
        cmd_code_i   = CMD_STATUS_CLEAR;
        status_set_i = PAT;
        @(negedge clock_i);
        cmd_valid_i  = 1'b0;
        status_set_i = '0;
        check(status_o, PAT);
        cmd(CMD_STATUS_CLEAR);
        check(status_o, STATUS_RESET);
    endtask
    task automatic run_unknown();
        @(negedge clock_i);
        status_set_i = PAT;
        @(negedge clock_i);
        status_set_i = '0;
        cmd(BAD_CODE);
        @(negedge clock_i);
        check(32'({tx_valid_o, busy_o, soft_reset_o}), 32'h0);
        check(status_o, PAT);
    endtask
    task automatic run_soft_reset();
        cmd(CMD_SOFT_RESET);
        check(32'(soft_reset_o), 32'h1);
        @(negedge clock_i);
        check(status_o, STATUS_RESET);
        check(32'({tx_valid_o, busy_o, soft_reset_o}), 32'h0);
        run_version();
    endtask
    // Reset pulled in the middle of a reply must leave nothing behind.
    task automatic run_hard_reset();
        @(negedge clock_i);
        status_set_i = PAT;
        slow         = 1'b1;
        @(negedge clock_i);
        status_set_i = '0;
        cmd(CMD_STATUS_READ);
        check(32'(busy_o), 32'h1);
        rst_b_i = 1'b0;
        repeat (2) @(negedge clock_i);
        check(status_o, STATUS_RESET);
        check(32'({tx_valid_o, busy_o, soft_reset_o}), 32'h0);
        rst_b_i = 1'b1;
        slow    = 1'b0;
        run_version();
        check(status_o, STATUS_RESET);
    endtask
    initial
    begin
        {cmd_valid_i, cmd_code_i, status_set_i, slow, rst_b_i} = '0;
        repeat (20) @(negedge clock_i);
        rst_b_i = 1'b1;
        run_version();
        run_status();
        run_clear();
        run_unknown();
        run_soft_reset();
        run_hard_reset();
        summarize();
    end
endmodule
`default_nettype wire
